// file: rtl/txcwd_decoder.sv
// Transmit command word decoder: parses the two command words ahead of each
// buffer, forwards buffer data, checks the packet length and reports status.
// Assumes words arrive one per valid cycle and are always accepted.
//
// Behaviour
// - First word bits 13/12 open and close packets.
// - Byte count plus alignment sets trailing word count.
// - Length mismatch against summed counts sets error.
// - Packet tag copied into the status word.
// - Tag value carries no meaning for hardware.
// - Checksum only with request, first segment, enable.
// - Second word bit 13 suppresses frame check sequence.
// - Bit 12 stops padding and forces check sequence.
// - Order: first word, second word, then data.
// - Alignment padding words are discarded by device.
`timescale 1ns/10ps
module txcwd_decoder (
  input wire logic clock_i,
  input wire logic rstn_i,
  input txcwd_pkg::txcwd_word_t word_i,
  input wire logic tx_checksum_engine_enable_i,
  input wire logic error_clear_i,
  output txcwd_pkg::txcwd_dout_t data_o,
  output txcwd_pkg::txcwd_ctl_t pkt_ctl_o,
  output txcwd_pkg::txcwd_status_t status_o,
  output logic transmitter_error_flag_o
);
  import txcwd_pkg::*;

  typedef struct packed {
    txcwd_state_t st;
    logic [10:0] bc;
    logic [1:0] align;
    logic fs;
    logic ls;
    logic [9:0] didx;
    logic [15:0] sum;
    logic err;
    logic pkt_err;
    txcwd_ctl_t ctl;
    txcwd_dout_t dout;
    txcwd_status_t status;
  } txcwd_regs_t;

  txcwd_regs_t r_reg;
  txcwd_regs_t r_next;
  logic [9:0] total_words;
  logic [9:0] data_words;
  logic fin;
  logic set_err;

  // Word counts for the buffer whose first command word is latched.
  txcwd_word_count u_count (
    .byte_cnt_i(r_reg.bc),
    .align_i(r_reg.align),
    .total_words_o(total_words),
    .data_words_o(data_words)
  );

  // Parser. Reserved bits are ignored rather than checked, so a host that
  // leaves them dirty still works today but gains nothing in future.
  always_comb begin
    r_next = r_reg;
    r_next.dout.valid = 1'b0;
    r_next.dout.last = 1'b0;
    r_next.status.valid = 1'b0;
    fin = 1'b0;
    set_err = 1'b0;
    if (error_clear_i) begin
      r_next.err = 1'b0;
    end
    if (word_i.valid) begin
      case (r_reg.st)
        S_CMD_A: begin
          r_next.bc = word_i.data[A_BYTE_CNT_MSB:0];
          r_next.align = word_i.data[A_ALIGN_MSB:A_ALIGN_LSB];
          r_next.fs = word_i.data[A_FIRST_SEG_BIT];
          r_next.ls = word_i.data[A_LAST_SEG_BIT];
          r_next.st = S_CMD_B;
        end
        S_CMD_B: begin
          r_next.didx = IDX_RST;
          if (r_reg.fs && !r_reg.ctl.active) begin
            // Controls latch once per packet and stand until it closes.
            r_next.ctl.active = 1'b1;
            r_next.ctl.tag = word_i.data[B_TAG_MSB:B_TAG_LSB];
            r_next.ctl.len = word_i.data[B_LEN_MSB:0];
            r_next.ctl.checksum = word_i.data[B_CHECKSUM_BIT] &
                tx_checksum_engine_enable_i;
            r_next.ctl.no_pad = word_i.data[B_PAD_DIS_BIT];
            r_next.ctl.no_fcs = word_i.data[B_CRC_DIS_BIT] &
                ~word_i.data[B_PAD_DIS_BIT];
            r_next.sum = {5'h00, r_reg.bc};
            r_next.pkt_err = 1'b0;
          end else begin
            // An opening segment inside a packet, or a middle buffer with no
            // packet open, is itself a length fault.
            set_err = 1'b1;
            if (r_reg.ctl.active) begin
              set_err = r_reg.fs;
            end
            r_next.sum = r_reg.sum + {5'h00, r_reg.bc};
            // Keep any segment fault so the closing status reports it too.
            r_next.pkt_err = r_reg.pkt_err | set_err;
          end
          if (total_words == IDX_RST) begin
            fin = 1'b1;
          end else begin
            r_next.st = S_DATA;
          end
        end
        S_DATA: begin
          // Only words holding buffer bytes pass; the aligned tail is eaten.
          if (r_reg.didx < data_words) begin
            r_next.dout.valid = 1'b1;
            r_next.dout.data = word_i.data;
            r_next.dout.last = r_reg.ls && (r_reg.didx == data_words - 10'h001);
          end
          r_next.didx = r_reg.didx + 10'h001;
          if (r_reg.didx == total_words - 10'h001) begin
            fin = 1'b1;
          end
        end
        default: begin
          r_next.st = S_CMD_A;
        end
      endcase
    end
    // Buffer end; a closing segment settles the length check and status.
    if (fin) begin
      r_next.st = S_CMD_A;
      if (r_reg.ls) begin
        r_next.ctl.active = 1'b0;
        r_next.status.valid = 1'b1;
        r_next.status.word = WORD_RST;
        r_next.status.word[B_TAG_MSB:B_TAG_LSB] = r_next.ctl.tag;
        if (r_next.pkt_err || (r_next.sum != {5'h00, r_next.ctl.len})) begin
          set_err = 1'b1;
          r_next.status.word[STAT_ERR_BIT] = 1'b1;
        end
      end
    end
    // A new fault wins over a clear in the same cycle.
    if (set_err) begin
      r_next.err = 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register.
  assign data_o = r_reg.dout;
  assign pkt_ctl_o = r_reg.ctl;
  assign status_o = r_reg.status;
  assign transmitter_error_flag_o = r_reg.err;

  // Opening of a packet as seen at the control outputs.
  sequence s_open;
    $rose(r_reg.ctl.active);
  endsequence

  // Second command word taken for a first segment with no packet open.
  sequence s_cmd_b_first;
    word_i.valid && r_reg.st == S_CMD_B && r_reg.fs && !r_reg.ctl.active;
  endsequence

  property p_err_on_mismatch;
    @(posedge clock_i) disable iff (!rstn_i)
    status_o.valid && status_o.word[STAT_ERR_BIT] |-> transmitter_error_flag_o;
  endproperty
  a_err_on_mismatch: assert property (p_err_on_mismatch)
    else $error("Length mismatch reported without error flag.");

  property p_err_sticky;
    @(posedge clock_i) disable iff (!rstn_i)
    transmitter_error_flag_o && !error_clear_i |=> transmitter_error_flag_o;
  endproperty
  a_err_sticky: assert property (p_err_sticky)
    else $error("Error flag dropped without a clear.");

  property p_tag_copy;
    @(posedge clock_i) disable iff (!rstn_i)
    status_o.valid |-> status_o.word[B_TAG_MSB:B_TAG_LSB] == pkt_ctl_o.tag;
  endproperty
  a_tag_copy: assert property (p_tag_copy)
    else $error("Status tag differs from packet tag.");

  property p_checksum;
    @(posedge clock_i) disable iff (!rstn_i)
    s_cmd_b_first |=> pkt_ctl_o.checksum ==
        ($past(word_i.data[B_CHECKSUM_BIT]) && $past(tx_checksum_engine_enable_i));
  endproperty
  a_checksum: assert property (p_checksum)
    else $error("Checksum request not the AND of its three conditions.");

  property p_no_fcs;
    @(posedge clock_i) disable iff (!rstn_i)
    s_cmd_b_first |=> pkt_ctl_o.no_fcs ==
        ($past(word_i.data[B_CRC_DIS_BIT]) && !$past(word_i.data[B_PAD_DIS_BIT]));
  endproperty
  a_no_fcs: assert property (p_no_fcs)
    else $error("Check sequence suppression decoded wrongly.");

  property p_no_pad_keeps_fcs;
    @(posedge clock_i) disable iff (!rstn_i)
    s_open ##0 pkt_ctl_o.no_pad |-> !pkt_ctl_o.no_fcs;
  endproperty
  a_no_pad_keeps_fcs: assert property (p_no_pad_keeps_fcs)
    else $error("Padding disabled but check sequence suppressed.");

  property p_hold_ctl;
    @(posedge clock_i) disable iff (!rstn_i)
    pkt_ctl_o.active && $past(pkt_ctl_o.active) |->
        $stable(pkt_ctl_o.tag) && $stable(pkt_ctl_o.len) && $stable(pkt_ctl_o.no_pad);
  endproperty
  a_hold_ctl: assert property (p_hold_ctl)
    else $error("Packet controls changed inside a packet.");

  property p_data_after_cmds;
    @(posedge clock_i) disable iff (!rstn_i)
    data_o.valid |-> $past(r_reg.st) == S_DATA && $past(word_i.valid);
  endproperty
  a_data_after_cmds: assert property (p_data_after_cmds)
    else $error("Data emitted outside the data phase.");

  property p_pad_dropped;
    @(posedge clock_i) disable iff (!rstn_i)
    data_o.valid |-> $past(r_reg.didx) < $past(data_words);
  endproperty
  a_pad_dropped: assert property (p_pad_dropped)
    else $error("Alignment padding word passed to the output.");

  property p_last_closes;
    @(posedge clock_i) disable iff (!rstn_i)
    data_o.valid && data_o.last |-> $past(r_reg.ls) && $past(r_reg.st) == S_DATA;
  endproperty
  a_last_closes: assert property (p_last_closes)
    else $error("Last data word outside a closing segment.");

endmodule : txcwd_decoder

// file: rtl/txcwd_pkg.sv
// Package for the transmit command word decoder: command word field layout,
// reset values and the carrier structs shared by the decoder and its helpers.
// Assumes a single 32-bit word stream fed from the transmit data FIFO.
package txcwd_pkg;

  // First command word fields.
  localparam int unsigned A_FIRST_SEG_BIT = 13;
  localparam int unsigned A_LAST_SEG_BIT = 12;
  localparam int unsigned A_RSVD_BIT = 11;
  localparam int unsigned A_BYTE_CNT_MSB = 10;
  localparam int unsigned A_ALIGN_LSB = 24;
  localparam int unsigned A_ALIGN_MSB = 25;

  // Second command word fields.
  localparam int unsigned B_TAG_LSB = 16;
  localparam int unsigned B_TAG_MSB = 31;
  localparam int unsigned B_RSVD_HI_BIT = 15;
  localparam int unsigned B_CHECKSUM_BIT = 14;
  localparam int unsigned B_CRC_DIS_BIT = 13;
  localparam int unsigned B_PAD_DIS_BIT = 12;
  localparam int unsigned B_LEN_MSB = 10;

  // Status word error bit.
  localparam int unsigned STAT_ERR_BIT = 15;

  // End alignment encodings; any other code falls back to 4 bytes.
  localparam logic [1:0] ALIGN_4 = 2'h0;
  localparam logic [1:0] ALIGN_16 = 2'h1;
  localparam logic [1:0] ALIGN_32 = 2'h2;

  // Reset values.
  localparam logic [15:0] SUM_RST = 16'h0000;
  localparam logic [9:0] IDX_RST = 10'h000;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    S_CMD_A,
    S_CMD_B,
    S_DATA
  } txcwd_state_t;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } txcwd_word_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic [31:0] data;
  } txcwd_dout_t;

  typedef struct packed {
    logic active;
    logic [15:0] tag;
    logic [10:0] len;
    logic checksum;
    logic no_fcs;
    logic no_pad;
  } txcwd_ctl_t;

  typedef struct packed {
    logic valid;
    logic [31:0] word;
  } txcwd_status_t;

endpackage : txcwd_pkg

// file: rtl/txcwd_word_count.sv
// Word count helper: turns a buffer byte count and its end alignment into
// the number of words the buffer occupies and how many of them carry data.
// Purely combinational; the caller registers whatever it needs.
`timescale 1ns/10ps
module txcwd_word_count (
  input wire logic [10:0] byte_cnt_i,
  input wire logic [1:0] align_i,
  output logic [9:0] total_words_o,
  output logic [9:0] data_words_o
);
  import txcwd_pkg::*;

  logic [11:0] mask;
  logic [11:0] rounded;
  logic [11:0] data_bytes;

  // Round up to the alignment boundary; the padded tail is dropped later.
  always_comb begin
    if (align_i == ALIGN_32) begin
      mask = 12'h01F;
    end else if (align_i == ALIGN_16) begin
      mask = 12'h00F;
    end else begin
      mask = 12'h003;
    end
    rounded = ({1'b0, byte_cnt_i} + mask) & ~mask;
    data_bytes = {1'b0, byte_cnt_i} + 12'h003;
    total_words_o = rounded[11:2];
    data_words_o = data_bytes[11:2];
  end

endmodule : txcwd_word_count

// file: dv/txcwd_host_model.sv
// Host model for the transmit command word decoder: writes buffers into the
// word stream as the host does through the transmit data FIFO.
// Assumes the decoder takes a word at every rising edge with valid high.
`timescale 1ns/10ps
module txcwd_host_model (
  input wire logic clock_i,
  output txcwd_pkg::txcwd_word_t word_o
);
  import txcwd_pkg::*;
  int seed = 32'h0757;
  // Rotating signature of the words that must reach the data output.
  logic [31:0] sig;

  initial word_o = '{valid: 1'b0, data: 32'h0000_0000};

  // Releases the stream; data flips so a stale word never looks valid.
  task automatic idle();
    @(negedge clock_i);
    word_o.valid = 1'b0;
    word_o.data = ~word_o.data;
  endtask : idle

  // Presents one word, sometimes after a random gap, since spacing is free.
  task automatic put(input logic [31:0] w);
    if (($random(seed) & 3) == 0) idle();
    @(negedge clock_i);
    word_o.valid = 1'b1;
    word_o.data = w;
  endtask : put

  // Sends one whole buffer: both command words, the data and its end padding.
  task automatic send_buf(input logic fs, input logic ls, input logic [10:0] bc,
      input logic [1:0] al, input logic [15:0] tag, input logic [10:0] len,
      input logic [2:0] ctl);
    int unit;
    int nw;
    logic [31:0] w;
    // Code 3 has no boundary of its own and falls back to 4 bytes.
    unit = (al == 2'h1) ? 4 : (al == 2'h2) ? 8 : 1;
    nw = ((int'(bc) + 4 * unit - 1) / (4 * unit)) * unit;
    put({6'h00, al, 10'h000, fs, ls, 1'b0, bc});
    put({tag, 1'b0, ctl, 1'b0, len});
    for (int i = 0; i < nw; i++) begin
      w = $random(seed);
      if (i < (int'(bc) + 3) / 4) sig = {sig[30:0], sig[31]} ^ w;
      put(w);
    end
    idle();
  endtask : send_buf
endmodule : txcwd_host_model

// file: dv/tb.sv
// Testbench for the transmit command word decoder: random packets of one to
// three buffers, length errors and orphan buffers, checked at the ports.
// Assumes the host model in this folder and the design package.
`timescale 1ns/10ps
`define CHK(n, e, g) begin comparisons++; if ((e) !== (g)) begin num_errors++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module tb;
  import txcwd_pkg::*;
  logic clock_i, rstn_i, tx_checksum_engine_enable_i, error_clear_i;
  txcwd_word_t word_i;
  txcwd_dout_t data_o;
  txcwd_ctl_t pkt_ctl_o;
  txcwd_status_t status_o;
  logic transmitter_error_flag_o;
  int num_errors = 0;
  int comparisons = 0;
  int n_data;
  int seed = 32'h0757;
  logic st_seen, last_seen;
  logic [31:0] st_word, sig_seen;

  txcwd_decoder u_txcwd_decoder (.clock_i(clock_i), .rstn_i(rstn_i), .word_i(word_i),
    .tx_checksum_engine_enable_i(tx_checksum_engine_enable_i),
    .error_clear_i(error_clear_i), .data_o(data_o), .pkt_ctl_o(pkt_ctl_o),
    .status_o(status_o), .transmitter_error_flag_o(transmitter_error_flag_o));
  txcwd_host_model u_txcwd_host_model (.clock_i(clock_i), .word_o(word_i));

  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  // Counts forwarded words and keeps the latest status, sampled mid-cycle where settled.
  always @(negedge clock_i) begin
    if (data_o.valid === 1'b1) begin
      n_data++;
      last_seen = data_o.last;
      sig_seen = {sig_seen[30:0], sig_seen[31]} ^ data_o.data;
    end
    if (status_o.valid === 1'b1) begin
      st_seen = 1'b1;
      st_word = status_o.word;
    end
  end

  task automatic final_report();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  // One packet; later buffers carry other controls, which must not take hold.
  task automatic run_pkt(input int nseg, input bit bad, input bit orphan,
      input logic [10:0] bc0);
    logic [10:0] bc [3];
    logic [10:0] sum;
    logic [15:0] tag;
    logic [2:0] ctl;
    logic en;
    logic err;
    int words;
    sum = 11'h000;
    words = 0;
    tag = 16'($random(seed));
    ctl = 3'($random(seed));
    en = 1'($random(seed));
    err = bad | orphan;
    for (int s = 0; s < nseg; s++) begin
      bc[s] = (s == 0 && bc0 != 11'h000) ? bc0 : 11'(($unsigned($random(seed)) % 200) + 4);
      sum = sum + bc[s];
      words += (int'(bc[s]) + 3) / 4;
    end
    @(negedge clock_i);
    error_clear_i = 1'b1;
    tx_checksum_engine_enable_i = en;
    @(negedge clock_i);
    error_clear_i = 1'b0;
    `CHK("error_cleared", 1'b0, transmitter_error_flag_o)
    n_data = 0;
    st_seen = 1'b0;
    last_seen = 1'b0;
    sig_seen = 32'h0000_0000;
    u_txcwd_host_model.sig = 32'h0000_0000;
    for (int s = 0; s < nseg; s++)
      u_txcwd_host_model.send_buf(!orphan && s == 0, s == nseg - 1, bc[s],
        2'($unsigned($random(seed)) % 4), (s == 0) ? tag : ~tag,
        (s == 0) ? (sum ^ {10'h000, bad}) : ~sum, (s == 0) ? ctl : ~ctl);
    // Step past the monitor's sample at each negedge so the counts are settled.
    #1;
    for (int k = 0; k < 10 && !st_seen; k++) begin
      @(negedge clock_i);
      #1;
    end
    if (!st_seen) begin
      num_errors++;
      final_report();
    end
    `CHK("data_words", words, n_data)
    `CHK("data_sig", u_txcwd_host_model.sig, sig_seen)
    `CHK("last_flag", 1'b1, last_seen)
    `CHK("status_error", err, st_word[STAT_ERR_BIT])
    `CHK("error_flag", err, transmitter_error_flag_o)
    if (!orphan) begin
      `CHK("status_word", {tag, err, 15'h0000}, st_word)
      `CHK("checksum", ctl[2] & en, pkt_ctl_o.checksum)
      `CHK("no_fcs", ctl[1] & ~ctl[0], pkt_ctl_o.no_fcs)
      `CHK("no_pad", ctl[0], pkt_ctl_o.no_pad)
      `CHK("len", sum ^ {10'h000, bad}, pkt_ctl_o.len)
      `CHK("active", 1'b0, pkt_ctl_o.active)
    end
  endtask : run_pkt

  // Hand-written corners first, then random packets with random errors.
  initial begin
    rstn_i = 1'b0;
    tx_checksum_engine_enable_i = 1'b0;
    error_clear_i = 1'b0;
    repeat (5) @(negedge clock_i);
    rstn_i = 1'b1;
    `CHK("reset_error", 1'b0, transmitter_error_flag_o)
    run_pkt(1, 1'b0, 1'b0, 11'h001);
    run_pkt(1, 1'b1, 1'b0, 11'h040);
    // Large first buffer, kept small enough that the sum fits the length field.
    run_pkt(3, 1'b0, 1'b0, 11'h600);
    run_pkt(1, 1'b0, 1'b1, 11'h000);
    run_pkt(2, 1'b1, 1'b0, 11'h000);
    repeat (40) run_pkt(1 + $unsigned($random(seed)) % 3, 1'($random(seed)), 1'b0, 11'h000);
    final_report();
  end
endmodule : tb
